// [hdl/nvas_ctrl.sv]
// Host controller driving an async 128K x 16 nonvolatile memory by its pins.
// Assumes the user holds a request stable until o_ready pulses with it taken.
//
// Functional notes
// RULE_01: Memory floats data within 20 ns of sleep low; host stops driving too.
// RULE_02: Sleep entry is immediate; chip select is ignored while asleep.
// RULE_03: After sleep release, wait 450 us before any access.
// RULE_04: Sleep may be requested right after the last write ends.
// RULE_05: After power-up, hold off every access for at least 1 ms.
// RULE_06: Write data latched on first rising edge of chip select or write strobe.
// RULE_07: Strobe-driven write starts as read; upper address latched at strobe fall.
// RULE_08: Column address held stable at least 15 ns per page access.
// RULE_09: Byte selects tied low only without byte writes; here always driven.
// RULE_10: Reads drive only selected bytes; floats with output enable high.
// RULE_11: Writes update only selected bytes, masking others.
// RULE_12: Column-only change under low chip select is a page access.
// RULE_13: Rising chip select precharges; new access needs chip select fall.
module nvas_ctrl #(
  parameter int POWER_UP_CYCLES = nvas_pkg::POWER_UP_CYC,
  parameter int SLEEP_EXIT_CYCLES = nvas_pkg::SLEEP_EXIT_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // User request
  input wire logic i_valid,
  input wire nvas_pkg::nvas_req_t i_req,
  input wire logic i_sleep,
  // User answer
  output logic o_ready,
  output logic o_rvalid,
  output logic [nvas_pkg::DATA_W-1:0] o_rdata,
  output logic o_asleep,
  // Memory pins
  output nvas_pkg::nvas_pins_t o_pins,
  input wire logic [nvas_pkg::DATA_W-1:0] i_dq,
  output logic [nvas_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe
);

  typedef enum logic [2:0] {
    S_POWERUP, S_IDLE, S_ACCESS, S_WSTROBE, S_DONE, S_PRECHG, S_SLEEP, S_WAKE
  } nvas_state_t;

  nvas_state_t state_q, state_d;
  nvas_pkg::nvas_pins_t pins_q, pins_d;
  logic [nvas_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [nvas_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q, rdata_q, rdata_d, dq_q, dq_d;
  logic dq_oe_q, dq_oe_d, ready_q, ready_d, rvalid_q, rvalid_d, wr_q, wr_d;

  ////////////////////////////////////////////////////////////////////////////
  wire cnt_done = (cnt_q == '0);
  wire [nvas_pkg::ADDR_W-nvas_pkg::COL_W-1:0] req_row =
    i_req.addr[nvas_pkg::ADDR_W-1:nvas_pkg::COL_W];
  wire [nvas_pkg::COL_W-1:0] req_col = i_req.addr[nvas_pkg::COL_W-1:0];
  wire same_row = (req_row == pins_q.row_address);
  wire page_hit = i_valid && !i_sleep && same_row && (i_req.write == wr_q); // RULE_12

  function automatic logic [nvas_pkg::CNT_W-1:0] cyc(input int n);
    cyc = nvas_pkg::CNT_W'(n - 1);
  endfunction : cyc

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    pins_d = pins_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
    rdata_d = rdata_q;
    dq_d = dq_q;
    dq_oe_d = dq_oe_q;
    ready_d = 1'b0;
    rvalid_d = 1'b0;
    wr_d = wr_q;
    case (state_q)
      S_POWERUP:
      begin
        if (cnt_done)
          state_d = S_IDLE; // RULE_05
      end
      S_IDLE:
      begin
        if (i_sleep)
        begin
          pins_d.sleep_request_n = 1'b0; // RULE_02 RULE_04
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          dq_oe_d = 1'b0; // RULE_01
          cnt_d = cyc(nvas_pkg::SLEEP_LOW_CYC);
          state_d = S_SLEEP;
        end
        else if (i_valid && !ready_q)
        begin
          pins_d.ce_n = 1'b0;
          pins_d.row_address = req_row;
          pins_d.column_address = req_col;
          pins_d.high_byte_sel_n = !i_req.byte_en[1]; // RULE_09 RULE_10 RULE_11
          pins_d.low_byte_sel_n = !i_req.byte_en[0];
          pins_d.oe_n = i_req.write;
          wr_d = i_req.write;
          dq_d = i_req.wdata;
          dq_oe_d = i_req.write;
          cnt_d = cyc(i_req.write ? nvas_pkg::SETUP_CYC : nvas_pkg::ACCESS_CYC);
          state_d = i_req.write ? S_WSTROBE : S_ACCESS; // RULE_07
        end
      end
      S_WSTROBE:
      begin
        // Strobe falls after address settled, so cycle starts as a read
        if (cnt_done)
        begin
          pins_d.we_n = 1'b0; // RULE_07
          cnt_d = cyc(nvas_pkg::WRITE_CYC);
          state_d = S_ACCESS;
        end
      end
      S_ACCESS:
      begin
        if (cnt_done)
        begin
          ready_d = 1'b1;
          if (wr_q)
            pins_d.we_n = 1'b1; // RULE_06
          else
          begin
            rdata_d = dq_s2_q;
            rvalid_d = 1'b1;
          end
          state_d = S_DONE;
        end
      end
      S_DONE:
      begin
        // Ready stands now; user already shows its next request
        begin
          if (page_hit && req_col != pins_q.column_address)
          begin
            // Page access: only the column moves, chip select stays low
            pins_d.column_address = req_col; // RULE_08 RULE_12
            pins_d.high_byte_sel_n = !i_req.byte_en[1];
            pins_d.low_byte_sel_n = !i_req.byte_en[0];
            dq_d = i_req.wdata;
            cnt_d = cyc(wr_q ? nvas_pkg::SETUP_CYC : nvas_pkg::PAGE_CYC);
            state_d = wr_q ? S_WSTROBE : S_ACCESS;
          end
          else
          begin
            pins_d.ce_n = 1'b1; // RULE_13
            pins_d.oe_n = 1'b1;
            cnt_d = cyc(nvas_pkg::PRECHARGE_CYC);
            state_d = S_PRECHG;
          end
        end
      end
      S_PRECHG:
      begin
        dq_oe_d = 1'b0;
        if (cnt_done)
          state_d = S_IDLE; // RULE_13
      end
      S_SLEEP:
      begin
        if (cnt_done && !i_sleep)
        begin
          pins_d.sleep_request_n = 1'b1;
          cnt_d = cyc(SLEEP_EXIT_CYCLES);
          state_d = S_WAKE;
        end
      end
      S_WAKE:
      begin
        if (cnt_done)
          state_d = S_IDLE; // RULE_03
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    dq_s1_q <= i_dq;
    dq_s2_q <= dq_s1_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= S_POWERUP;
      pins_q <= nvas_pkg::PINS_RESET;
      cnt_q <= cyc(POWER_UP_CYCLES);
      rdata_q <= '0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      ready_q <= 1'b0;
      rvalid_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pins_q <= pins_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      ready_q <= ready_d;
      rvalid_q <= rvalid_d;
      wr_q <= wr_d;
    end
  end

  logic asleep_q;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      asleep_q <= 1'b0;
    else
      asleep_q <= (state_d == S_SLEEP);
  end

  assign o_pins = pins_q;
  assign o_dq = dq_q;
  assign o_dq_oe = dq_oe_q;
  assign o_ready = ready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_asleep = asleep_q;

endmodule : nvas_ctrl

// [hdl/nvas_pkg.sv]
// Package for the host-side controller of a 128K x 16 nonvolatile async memory.
// Assumes a 100 MHz single clock; all pin timing derived from it.
package nvas_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int COL_W = 2;

  // Timing figures as printed, then derived cycle counts
  localparam int T_POWER_UP_MS = 1;
  localparam int T_SLEEP_EXIT_US = 450;
  localparam int T_SLEEP_LOW_US = 1;
  localparam int T_PRECHARGE_NS = 30;
  localparam int T_ACCESS_NS = 60;
  localparam int T_WRITE_PULSE_NS = 60;
  localparam int T_PAGE_ADDR_NS = 15;
  localparam int T_PAGE_ACCESS_NS = 25;
  localparam int T_DATA_SETUP_NS = 15;

  localparam int POWER_UP_CYC = (T_POWER_UP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_EXIT_CYC = (T_SLEEP_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_LOW_CYC = (T_SLEEP_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WRITE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC =
    ((T_PAGE_ACCESS_NS > T_PAGE_ADDR_NS ? T_PAGE_ACCESS_NS : T_PAGE_ADDR_NS)
     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 20;

  // Request from the user side
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] byte_en;
  } nvas_req_t;

  // Pins toward the memory; selects and strobes active low
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic high_byte_sel_n;
    logic low_byte_sel_n;
    logic sleep_request_n;
    logic [ADDR_W-COL_W-1:0] row_address;
    logic [COL_W-1:0] column_address;
  } nvas_pins_t;

  localparam nvas_pins_t PINS_RESET = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
    high_byte_sel_n: 1'b1, low_byte_sel_n: 1'b1, sleep_request_n: 1'b1,
    row_address: '0, column_address: '0};

endpackage : nvas_pkg

// [testbench/nvas_sva.sv]
// Pin timing checker for the memory controller.
// Bound into every nvas_ctrl instance.
module nvas_sva #(
  parameter int POWER_UP_CYCLES = 20,
  parameter int SLEEP_EXIT_CYCLES = 20
) (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire nvas_pkg::nvas_req_t i_req,
  input wire logic o_dq_oe,
  input wire nvas_pkg::nvas_pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int pu_q;
  int wk_q;
  always_ff @(posedge i_clk)
  begin
    pu_q <= !i_rst_n ? 0 : pu_q + 1;
    wk_q <= !i_rst_n || !o_pins.sleep_request_n ? 0 : wk_q + 1;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_power_up_wait: assert property (!o_pins.ce_n |-> pu_q >= POWER_UP_CYCLES)
    else $error("access too soon after reset");
  a_wake_wait: assert property (!o_pins.ce_n |-> wk_q >= SLEEP_EXIT_CYCLES)
    else $error("access too soon after wake");
  a_sleep_quiet: assert property (!o_pins.sleep_request_n |-> o_pins.ce_n && !o_dq_oe)
    else $error("sleep entered during an access");
  a_column_hold: assert property
    (!o_pins.ce_n && $changed(o_pins.column_address) |=> $stable(o_pins.column_address) [*2])
    else $error("column address held too briefly");
  a_byte_sel: assert property ($fell(o_pins.we_n) |->
    {o_pins.high_byte_sel_n, o_pins.low_byte_sel_n} == ~i_req.byte_en)
    else $error("byte selects differ from request");
endmodule : nvas_sva
bind nvas_ctrl nvas_sva #(.POWER_UP_CYCLES(POWER_UP_CYCLES),
  .SLEEP_EXIT_CYCLES(SLEEP_EXIT_CYCLES)) u_nvas_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_req(i_req), .o_dq_oe(o_dq_oe), .o_pins(o_pins));

// [testbench/nvas_mem_model.sv]
// Behavioural model of the async nonvolatile memory.
// Sees the resolved bus; unselected bytes show inverted data.
module nvas_mem_model (
  // Pins and bus from the host
  input wire nvas_pkg::nvas_pins_t i_pins,
  input wire logic [15:0] i_dq,
  // Data toward the host
  output logic [15:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_q [0:131071];
  logic [14:0] row_q;
  wire on = i_pins.sleep_request_n;
  wire [15:0] rd = mem_q[{i_pins.row_address, i_pins.column_address}];
  wire rdo = on && !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;
  assign o_dq[15:8] = rdo && !i_pins.high_byte_sel_n ? rd[15:8] : ~rd[15:8];
  assign o_dq[7:0] = rdo && !i_pins.low_byte_sel_n ? rd[7:0] : ~rd[7:0];
  always @(negedge i_pins.we_n or negedge i_pins.ce_n)
    row_q = i_pins.row_address;
  always @(posedge i_pins.we_n or posedge i_pins.ce_n)
  begin
    if (on && !(i_pins.we_n && i_pins.ce_n))
    begin
      if (!i_pins.high_byte_sel_n)
        mem_q[{row_q, i_pins.column_address}][15:8] = i_dq[15:8];
      if (!i_pins.low_byte_sel_n)
        mem_q[{row_q, i_pins.column_address}][7:0] = i_dq[7:0];
    end
  end
endmodule : nvas_mem_model

// [testbench/tb_top.sv]
// Self-checking bench: controller driving the memory model.
// Power-up and wake counts cut to 20 cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0;
  logic i_rst_n = 0;
  logic i_valid = 0;
  logic i_sleep = 0;
  nvas_pkg::nvas_req_t i_req = '0;
  nvas_pkg::nvas_pins_t pins;
  logic ready, rvalid, asleep, oe;
  logic [15:0] rdata, hdq, mdq;
  wire [15:0] dq = oe ? hdq : mdq;
  int errors = 0;
  int tests_run = 0;
  int ce_rises = 0;
  always @(posedge pins.ce_n) ce_rises++;
  nvas_ctrl #(.POWER_UP_CYCLES(20), .SLEEP_EXIT_CYCLES(20)) u_nvas_ctrl (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_req(i_req),
    .i_sleep(i_sleep), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
    .o_asleep(asleep), .o_pins(pins), .i_dq(dq), .o_dq(hdq), .o_dq_oe(oe));
  nvas_mem_model u_nvas_mem_model (.i_pins(pins), .i_dq(dq), .o_dq(mdq));
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic test_done();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic bad(string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : bad
  task automatic chk8(logic [7:0] g, logic [7:0] e);
    tests_run++;
    if (g !== e) bad("data");
  endtask : chk8
  task automatic chk1(logic g, logic e);
    tests_run++;
    if (g !== e) bad("flag");
  endtask : chk1
  task automatic step(int c);
    i_valid = 0;
    repeat (c) @(posedge i_clk);
    #1;
  endtask : step
  // One request, held until the completion pulse
  task automatic acc(logic w, logic [16:0] a, logic [15:0] d, logic [1:0] be);
    int n;
    n = 0;
    i_valid = 1;
    i_req = '{w, a, d, be};
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    while (ready !== 1'h1 && n < 300);
    if (n >= 300)
    begin
      bad("timeout");
      test_done();
    end
  endtask : acc
  task automatic rd(logic [16:0] a, logic [1:0] be, logic [15:0] e);
    acc(0, a, 0, be);
    chk1(rvalid, 1'h1);
    if (be[1]) chk8(rdata[15:8], e[15:8]);
    if (be[0]) chk8(rdata[7:0], e[7:0]);
  endtask : rd
  task automatic t_word();
    acc(1, 17'h00004, 16'ha5c3, 2'h3);
    rd(17'h00004, 2'h3, 16'ha5c3);
    step(1);
    $display("t_word done");
  endtask : t_word
  task automatic t_bytes();
    acc(1, 17'h00010, 16'h1234, 2'h3);
    acc(1, 17'h00010, 16'hff00, 2'h2);
    acc(1, 17'h00010, 16'h0000, 2'h0);
    rd(17'h00010, 2'h3, 16'hff34);
    rd(17'h00010, 2'h1, 16'hff34);
    rd(17'h00010, 2'h2, 16'hff34);
    step(1);
    $display("t_bytes done");
  endtask : t_bytes
  task automatic t_page();
    int base;
    base = ce_rises;
    for (int i = 0; i < 4; i++) acc(1, 17'h00100 + 17'(i), 16'hc000 + 16'(i), 2'h3);
    chk8(8'(ce_rises - base), 8'h00);
    for (int i = 0; i < 4; i++) rd(17'h00103 - 17'(i), 2'h3, 16'hc003 - 16'(i));
    chk8(8'(ce_rises - base), 8'h01);
    rd(17'h00004, 2'h3, 16'ha5c3);
    step(1);
    $display("t_page done");
  endtask : t_page
  task automatic t_sleep();
    acc(1, 17'h00020, 16'h5a5a, 2'h3);
    i_sleep = 1;
    for (int n = 0; n < 50 && asleep !== 1'h1; n++) step(1);
    if (asleep !== 1'h1)
    begin
      bad("timeout");
      test_done();
    end
    chk1(pins.sleep_request_n, 1'h0);
    step(110);
    chk1(asleep, 1'h1);
    i_sleep = 0;
    rd(17'h00020, 2'h3, 16'h5a5a);
    chk1(asleep, 1'h0);
    step(1);
    $display("t_sleep done");
  endtask : t_sleep
  initial
  begin
    repeat (5) @(posedge i_clk);
    #1;
    i_rst_n = 1;
    t_word();
    t_bytes();
    t_page();
    t_sleep();
    test_done();
  end
endmodule : tb_top
